// [logic/phy_cfg.svh]
// timing constants of the 10/100 datapath timing block
`ifndef PHY_CFG_SVH
`define PHY_CFG_SVH

// ----------------------------------------------------------------
// clock and bit times
// ----------------------------------------------------------------
`define PHY_CLK_NS 8
`define PHY_BIT_NS_FAST 10
`define PHY_BIT_NS_SLOW 100

// ----------------------------------------------------------------
// latencies in half bit times
// ----------------------------------------------------------------
`define PHY_TX_FAST_HB 12
`define PHY_TX_SLOW_HB 7
`define PHY_TX_RMII_HB 34
`define PHY_CRS_ON_FAST_HB 40
`define PHY_CRS_OFF_FAST_HB 48
`define PHY_CRS_OFF_SLOW_HB 2
`define PHY_DV_FAST_HB 48
`define PHY_DV_SLOW_HB 20
`define PHY_SFD_SLOW_HB 16

// ----------------------------------------------------------------
// times in ns, and the link pulse width in clock cycles
// ----------------------------------------------------------------
`define PHY_CRS_ON_SLOW_NS 630
`define PHY_EOP_NS 300
`define PHY_CK_FAST_NS 20
`define PHY_CK_MII10_NS 200
`define PHY_STX_HI_NS 25
`define PHY_STX_LO_NS 75
`define PHY_SRX_NS 50
`define PHY_LP_NS 100
`define PHY_LP_CYC ((`PHY_LP_NS + `PHY_CLK_NS - 1) / `PHY_CLK_NS)

// ----------------------------------------------------------------
// link pulses and signal detect
// ----------------------------------------------------------------
`define PHY_LP_PERIOD_MS 16
`define PHY_LP_PERIOD_CYC (`PHY_LP_PERIOD_MS * 1000000 / `PHY_CLK_NS)
`define PHY_FLP_SLOT_US 125
`define PHY_FLP_SLOT_CYC (`PHY_FLP_SLOT_US * 1000 / `PHY_CLK_NS)
`define PHY_FLP_DATA_US 62
`define PHY_FLP_DATA_CYC (`PHY_FLP_DATA_US * 1000 / `PHY_CLK_NS)
`define PHY_FLP_BURST_MS 2
`define PHY_FLP_SLOTS (`PHY_FLP_BURST_MS * 1000 / `PHY_FLP_SLOT_US)
`define PHY_DET_ON_MS 1
`define PHY_DET_ON_CYC (`PHY_DET_ON_MS * 1000000 / `PHY_CLK_NS)
`define PHY_DET_OFF_US 350
`define PHY_DET_OFF_CYC (`PHY_DET_OFF_US * 1000 / `PHY_CLK_NS)

`endif

// [logic/phy_pkg.sv]
// types of the 10/100 datapath timing block
package phy_pkg;

  typedef enum logic [3:0] {
    PHY_M_MII100 = 4'h1,
    PHY_M_MII10 = 4'h2,
    PHY_M_SER10 = 4'h4,
    PHY_M_RMII = 4'h8
  } phy_mode_t;

  typedef enum logic [4:0] {
    PHY_TX_IDLE = 5'h01,
    PHY_TX_LEAD = 5'h02,
    PHY_TX_DATA = 5'h04,
    PHY_TX_TAIL = 5'h08,
    PHY_TX_EOP = 5'h10
  } phy_tx_st_t;

  typedef struct packed {
    logic en;
    logic [3:0] d;
  } phy_mac_tx_t;

  typedef struct packed {
    logic clk;
    logic crs;
    logic dv;
    logic er;
    logic [3:0] d;
  } phy_mac_rx_t;

  typedef struct packed {
    logic active;
    logic sym_start;
    logic sym_end;
    logic eop_high;
    logic link_pulse;
    logic [3:0] d;
  } phy_line_tx_t;

  typedef struct packed {
    phy_mac_tx_t mtx_s1;
    phy_mac_tx_t mtx_s2;
    logic [2:0] ref_sy;
    logic [2:0] car_sy;
    logic [2:0] sfd_sy;
    logic [1:0] nrg_sy;
    logic txck;
    logic [7:0] txel;
    logic [7:0] rxel;
    logic samp;
    phy_tx_st_t st;
    logic [11:0] tdly;
    phy_line_tx_t ltx;
    logic [11:0] crs_dly;
    logic [11:0] dv_dly;
    logic [11:0] sfd_dly;
    logic dv_i;
    logic data_open;
    phy_mac_rx_t mrx;
    logic [20:0] per_cnt;
    logic [20:0] slot_cnt;
    logic [3:0] slot_idx;
    logic burst;
    logic [3:0] pw_cnt;
    logic [20:0] det_cnt;
    logic det;
  } phy_state_t;

endpackage : phy_pkg

// [logic/phy_datapath.sv]
// datapath timing of a 10/100 ethernet phy seen from the mac side
`timescale 1ns/1ns
`include "phy_cfg.svh"

module phy_datapath #(
  parameter int LP_PERIOD_CYC = `PHY_LP_PERIOD_CYC,
  parameter int FLP_SLOT_CYC = `PHY_FLP_SLOT_CYC,
  parameter int FLP_DATA_CYC = `PHY_FLP_DATA_CYC,
  parameter int DET_ON_CYC = `PHY_DET_ON_CYC,
  parameter int DET_OFF_CYC = `PHY_DET_OFF_CYC
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire phy_pkg::phy_mode_t mode,
  input wire logic autoneg_en,
  input wire logic [15:0] flp_word,
  input wire phy_pkg::phy_mac_tx_t mac_tx,
  input wire logic rmii_reference_clock_in,
  output logic mac_tx_clk,
  output phy_pkg::phy_mac_rx_t mac_rx,
  input wire logic line_rx_carrier,
  input wire logic line_rx_sfd,
  input wire logic [3:0] line_rx_data,
  input wire logic line_rx_err,
  input wire logic line_energy,
  output phy_pkg::phy_line_tx_t line_tx,
  output logic signal_detect_internal
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  localparam phy_pkg::phy_state_t RST_STATE =
    '{st: phy_pkg::PHY_TX_IDLE, default: '0};

  function automatic logic [8:0] clk_step(input logic ck,
    input logic [7:0] el, input logic [7:0] hi, input logic [7:0] lo);
    logic [7:0] tgt;
    logic [7:0] e;
    logic [7:0] rem;
    tgt = ck ? hi : lo;
    e = el + 8'(`PHY_CLK_NS);
    rem = e - tgt;
    if (e >= tgt)
    begin
      // a leftover from a longer old phase is dropped, so no shortening
      clk_step = {~ck, (rem < 8'(`PHY_CLK_NS)) ? rem : 8'h00};
    end
    else
    begin
      clk_step = {ck, e};
    end
  endfunction : clk_step

  function automatic logic [11:0] h2ns(input logic [7:0] hb,
    input logic [7:0] bns);
    logic [15:0] p;
    p = 16'(hb) * 16'(bns);
    h2ns = p[12:1];
  endfunction : h2ns

  function automatic logic [11:0] dly_step(input logic [11:0] c);
    dly_step = (c > 12'(`PHY_CLK_NS)) ? c - 12'(`PHY_CLK_NS) : 12'h000;
  endfunction : dly_step

  function automatic logic dly_fire(input logic [11:0] c);
    dly_fire = (c != 12'h000) && (c <= 12'(`PHY_CLK_NS));
  endfunction : dly_fire

  // ----------------------------------------------------------------
  // mode decode
  // ----------------------------------------------------------------
  phy_pkg::phy_state_t q;
  phy_pkg::phy_state_t n;
  logic slow;
  logic rmii;
  logic mii10;
  logic ser;
  logic [7:0] bit_ns;

  assign mii10 = (mode == phy_pkg::PHY_M_MII10);
  assign ser = (mode == phy_pkg::PHY_M_SER10);
  assign rmii = (mode == phy_pkg::PHY_M_RMII);
  assign slow = mii10 | ser;
  assign bit_ns = slow ? 8'(`PHY_BIT_NS_SLOW) : 8'(`PHY_BIT_NS_FAST);

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb
  begin
    logic ref_rise;
    logic tx_rise;
    logic tx_fall;
    logic rx_fall;
    logic samp;
    logic upd;
    logic car_rise;
    logic car_fall;
    logic sfd_rise;
    logic trig;
    logic [7:0] thi;
    logic [7:0] tlo;
    logic [7:0] rph;
    logic [7:0] tx_hb;
    ref_rise = 1'b0;
    tx_rise = 1'b0;
    tx_fall = 1'b0;
    rx_fall = 1'b0;
    samp = 1'b0;
    upd = 1'b0;
    car_rise = 1'b0;
    car_fall = 1'b0;
    sfd_rise = 1'b0;
    trig = 1'b0;
    thi = 8'(`PHY_CK_FAST_NS);
    tlo = 8'(`PHY_CK_FAST_NS);
    rph = 8'(`PHY_CK_FAST_NS);
    tx_hb = 8'(`PHY_TX_FAST_HB);
    n = q;

    // pin synchronisers
    n.mtx_s1 = mac_tx;
    n.mtx_s2 = q.mtx_s1;
    n.ref_sy = {q.ref_sy[1:0], rmii_reference_clock_in};
    n.car_sy = {q.car_sy[1:0], line_rx_carrier};
    n.sfd_sy = {q.sfd_sy[1:0], line_rx_sfd};
    n.nrg_sy = {q.nrg_sy[0], line_energy};
    ref_rise = q.ref_sy[1] & ~q.ref_sy[2];
    car_rise = q.car_sy[1] & ~q.car_sy[2];
    car_fall = ~q.car_sy[1] & q.car_sy[2];
    sfd_rise = q.sfd_sy[1] & ~q.sfd_sy[2];

    // interface clocks
    if (mii10)
    begin
      thi = 8'(`PHY_CK_MII10_NS);
      tlo = 8'(`PHY_CK_MII10_NS);
      rph = 8'(`PHY_CK_MII10_NS);
      tx_hb = 8'(`PHY_TX_SLOW_HB);
    end
    else if (ser)
    begin
      thi = 8'(`PHY_STX_HI_NS);
      tlo = 8'(`PHY_STX_LO_NS);
      rph = 8'(`PHY_SRX_NS);
      tx_hb = 8'(`PHY_TX_SLOW_HB);
    end
    else if (rmii)
    begin
      tx_hb = 8'(`PHY_TX_RMII_HB);
    end
    {n.txck, n.txel} = clk_step(q.txck, q.txel, thi, tlo);
    {n.mrx.clk, n.rxel} = clk_step(q.mrx.clk, q.rxel, rph, rph);
    tx_rise = n.txck & ~q.txck;
    tx_fall = ~n.txck & q.txck;
    rx_fall = ~n.mrx.clk & q.mrx.clk;

    // transmit sampling edge; the mac drives on the tx clock rising edge, in rmii on the reference falling edge
    if (rmii)
      samp = ref_rise;
    else if (mii10)
      samp = tx_fall;
    else
      samp = tx_rise;
    n.samp = samp;
    if (samp)
    begin
      if (rmii)
        n.ltx.d = {2'h0, q.mtx_s2.d[1:0]};
      else if (ser)
        n.ltx.d = {3'h0, q.mtx_s2.d[0]};
      else
        n.ltx.d = q.mtx_s2.d;
    end

    // transmit frame sequence
    n.ltx.sym_start = 1'b0;
    n.ltx.sym_end = 1'b0;
    n.tdly = dly_step(q.tdly);
    unique case (q.st)
      phy_pkg::PHY_TX_IDLE:
      begin
        if (samp && q.mtx_s2.en)
        begin
          n.st = phy_pkg::PHY_TX_LEAD;
          n.tdly = h2ns(tx_hb, bit_ns);
        end
      end
      phy_pkg::PHY_TX_LEAD:
      begin
        if (dly_fire(q.tdly))
        begin
          n.st = phy_pkg::PHY_TX_DATA;
          n.ltx.active = 1'b1;
          n.ltx.sym_start = 1'b1;
        end
      end
      phy_pkg::PHY_TX_DATA:
      begin
        if (samp && !q.mtx_s2.en)
        begin
          n.st = phy_pkg::PHY_TX_TAIL;
          n.tdly = h2ns(tx_hb, bit_ns);
        end
      end
      phy_pkg::PHY_TX_TAIL:
      begin
        if (dly_fire(q.tdly))
        begin
          n.ltx.sym_end = 1'b1;
          n.ltx.active = 1'b0;
          if (slow)
          begin
            n.st = phy_pkg::PHY_TX_EOP;
            n.ltx.eop_high = 1'b1;
            n.tdly = 12'(`PHY_EOP_NS);
          end
          else
          begin
            n.st = phy_pkg::PHY_TX_IDLE;
          end
        end
      end
      phy_pkg::PHY_TX_EOP:
      begin
        if (dly_fire(q.tdly))
        begin
          n.ltx.eop_high = 1'b0;
          n.st = phy_pkg::PHY_TX_IDLE;
        end
      end
      default:
      begin
        n.st = phy_pkg::PHY_TX_IDLE;
      end
    endcase

    // receive carrier, valid and data timing
    n.crs_dly = dly_step(q.crs_dly);
    n.dv_dly = dly_step(q.dv_dly);
    n.sfd_dly = dly_step(q.sfd_dly);
    if (dly_fire(q.crs_dly))
    begin
      n.mrx.crs = q.car_sy[2];
      if (!q.car_sy[2])
      begin
        n.dv_i = 1'b0;
        n.data_open = 1'b0;
      end
    end
    if (dly_fire(q.dv_dly))
    begin
      n.dv_i = 1'b1;
      if (!slow)
        n.data_open = 1'b1;
    end
    if (dly_fire(q.sfd_dly))
      n.data_open = 1'b1;
    if (car_rise)
    begin
      n.crs_dly = slow ? 12'(`PHY_CRS_ON_SLOW_NS) :
        h2ns(8'(`PHY_CRS_ON_FAST_HB), bit_ns);
      n.dv_dly = h2ns(slow ? 8'(`PHY_DV_SLOW_HB) :
        8'(`PHY_DV_FAST_HB), bit_ns);
    end
    if (car_fall)
    begin
      n.crs_dly = h2ns(slow ? 8'(`PHY_CRS_OFF_SLOW_HB) :
        8'(`PHY_CRS_OFF_FAST_HB), bit_ns);
      n.dv_dly = 12'h000;
      n.sfd_dly = 12'h000;
    end
    if (sfd_rise && slow)
      n.sfd_dly = h2ns(8'(`PHY_SFD_SLOW_HB), bit_ns);

    // rx valid, error and data change on the falling edge, stable about the rising; in rmii they change on the reference rising edge
    upd = rmii ? ref_rise : rx_fall;
    if (upd)
    begin
      n.mrx.dv = q.dv_i;
      n.mrx.er = q.dv_i & line_rx_err;
      n.mrx.d = q.data_open ? line_rx_data : 4'h5;
    end

    // link pulses; each nlp and each flp burst is started only while the transmitter is idle
    n.per_cnt = (q.per_cnt == 21'(LP_PERIOD_CYC - 1)) ? 21'h000000 :
      q.per_cnt + 21'h000001;
    if (q.burst)
    begin
      if (q.slot_cnt == 21'h000000)
        trig = 1'b1;
      if (q.slot_cnt == 21'(FLP_DATA_CYC) && flp_word[q.slot_idx])
        trig = 1'b1;
      n.slot_cnt = q.slot_cnt + 21'h000001;
      if (q.slot_cnt == 21'(FLP_SLOT_CYC - 1))
      begin
        n.slot_cnt = 21'h000000;
        n.slot_idx = q.slot_idx + 4'h1;
        if (q.slot_idx == 4'(`PHY_FLP_SLOTS - 1))
          n.burst = 1'b0;
      end
    end
    if (q.per_cnt == 21'h000000 && q.st == phy_pkg::PHY_TX_IDLE)
    begin
      if (autoneg_en)
      begin
        n.burst = 1'b1;
        n.slot_cnt = 21'h000000;
        n.slot_idx = 4'h0;
      end
      else
      begin
        trig = 1'b1;
      end
    end
    if (trig)
      n.pw_cnt = 4'(`PHY_LP_CYC);
    else if (q.pw_cnt != 4'h0)
      n.pw_cnt = q.pw_cnt - 4'h1;
    n.ltx.link_pulse = (n.pw_cnt != 4'h0);

    // signal detect with separate on and off filters
    if (q.nrg_sy[1] == q.det)
    begin
      n.det_cnt = 21'h000000;
    end
    else
    begin
      n.det_cnt = q.det_cnt + 21'h000001;
      if (q.det_cnt == (q.det ? 21'(DET_OFF_CYC - 1) : 21'(DET_ON_CYC - 1)))
      begin
        n.det = ~q.det;
        n.det_cnt = 21'h000000;
      end
    end
  end

  // ----------------------------------------------------------------
  // state register and outputs
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk)
  begin
    if (rst)
      q <= RST_STATE;
    else
      q <= n;
  end

  assign mac_tx_clk = q.txck;
  assign mac_rx = q.mrx;
  assign line_tx = q.ltx;
  assign signal_detect_internal = q.det;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);

  tx_j_lat_a: assert property (
    $changed(q.st) && q.st == phy_pkg::PHY_TX_LEAD &&
    mode == phy_pkg::PHY_M_MII100 |-> (!q.ltx.sym_start)[*8])
    else $error("j symbol earlier than 6 bit times");

  tx_j_time_a: assert property (
    $changed(q.st) && q.st == phy_pkg::PHY_TX_LEAD &&
    mode == phy_pkg::PHY_M_MII100 |-> ##8 q.ltx.sym_start)
    else $error("j symbol not 6 bit times after edge");

  tx_t_time_a: assert property (
    $changed(q.st) && q.st == phy_pkg::PHY_TX_TAIL &&
    mode == phy_pkg::PHY_M_MII100 |-> ##8 q.ltx.sym_end)
    else $error("t symbol not 6 bit times after edge");

  crs_on_a: assert property (
    $rose(q.car_sy[1]) && !slow |->
    ##26 (q.mrx.crs || !q.car_sy[2]))
    else $error("carrier sense late at 100M");

  crs_off_a: assert property (
    $fell(q.car_sy[1]) && !slow |->
    ##31 (!q.mrx.crs || q.car_sy[2]))
    else $error("carrier sense not dropped at 100M");

  mii10_samp_a: assert property (
    q.samp && mii10 |-> !q.txck && $past(q.txck))
    else $error("10M mii sample not on falling clock");

  ser_clk_a: assert property (
    $rose(q.txck) && ser && $stable(mode) |-> q.txck[*3] ##1 1'b1)
    else $error("serial tx clock high phase too short");

  eop_hold_a: assert property (
    $rose(q.ltx.eop_high) |-> q.ltx.eop_high[*8])
    else $error("end of packet high too short");

  crs10_on_a: assert property (
    $rose(q.car_sy[1]) && slow |->
    ##80 (q.mrx.crs || !q.car_sy[2]))
    else $error("10M carrier sense late");

  lp_width_a: assert property (
    $rose(q.ltx.link_pulse) |-> q.ltx.link_pulse[*8])
    else $error("link pulse too narrow");

  rmii_samp_a: assert property (
    q.samp && rmii |-> $past(q.ref_sy[1]) && !$past(q.ref_sy[2]))
    else $error("rmii sample not on reference rising edge");

endmodule : phy_datapath

// [tb/phy_mac_model.sv]
// mac-side partner model feeding the transmit pins of the phy datapath
`timescale 1ns/1ns
module phy_mac_model (
  input wire logic mac_tx_clk,
  input wire logic rmii_reference_clock_in,
  input wire phy_pkg::phy_mode_t mode,
  input wire logic go,
  output phy_pkg::phy_mac_tx_t mac_tx
);
  logic [3:0] nib_ff = 4'h0;
  logic rmii;

  assign rmii = (mode === phy_pkg::PHY_M_RMII);

  initial mac_tx = '0;

  // ----------------------------------------------------------------
  // frame source
  // ----------------------------------------------------------------
  // idle data is inverted every edge so a stale nibble never looks valid
  task automatic step();
    mac_tx.en <= go;
    nib_ff <= nib_ff + 4'h1;
    mac_tx.d <= go ? nib_ff : ~mac_tx.d;
  endtask : step

  always @(posedge mac_tx_clk)
    if (!rmii)
      step();
  // the reference is sampled through synchronisers, so rmii data moves
  // half a period away from the rising edge that the phy samples on
  always @(negedge rmii_reference_clock_in)
    if (rmii)
      step();
endmodule : phy_mac_model

// [tb/phy_datapath_bench.sv]
// self-checking bench of the phy datapath timing block
`timescale 1ns/1ns
module phy_datapath_bench;
  localparam int LP = 4000;
  localparam int SLOT = 200;
  localparam int DATA = 100;
  localparam int DET_ON = 64;
  localparam int DET_OFF = 32;
  // probe bit positions
  localparam int DET = 0, LPB = 1, EOP = 2, SE = 3, SS = 4, DV = 5, CRS = 6;
  localparam int RCK = 7, TCK = 8, EN = 9, REF = 10, DC = 11;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  phy_pkg::phy_mode_t mode = phy_pkg::PHY_M_MII100;
  logic autoneg_en = 1'b0;
  logic [15:0] flp_word = 16'hA5A5;
  logic rmii_reference_clock_in = 1'b0;
  logic go = 1'b0;
  logic carrier = 1'b0;
  logic sfd = 1'b0;
  logic energy = 1'b0;
  logic rx_err = 1'b0;
  phy_pkg::phy_mac_tx_t mac_tx;
  logic mac_tx_clk;
  phy_pkg::phy_mac_rx_t mac_rx;
  phy_pkg::phy_line_tx_t line_tx;
  logic sdi;
  logic [11:0] pr;
  int n_fail = 0;
  int samples_checked = 0;

  assign pr = {(mac_rx.d === 4'hC), rmii_reference_clock_in, mac_tx.en,
    mac_tx_clk, mac_rx.clk, mac_rx.crs, mac_rx.dv, line_tx.sym_start,
    line_tx.sym_end, line_tx.eop_high, line_tx.link_pulse, sdi};

  initial forever #4 sys_clk = ~sys_clk;
  initial
  begin
    #3;
    forever #32 rmii_reference_clock_in = ~rmii_reference_clock_in;
  end

  phy_datapath #(.LP_PERIOD_CYC(LP), .FLP_SLOT_CYC(SLOT),
    .FLP_DATA_CYC(DATA), .DET_ON_CYC(DET_ON), .DET_OFF_CYC(DET_OFF)) dut (
    .sys_clk(sys_clk), .rst(rst), .mode(mode), .autoneg_en(autoneg_en),
    .flp_word(flp_word), .mac_tx(mac_tx),
    .rmii_reference_clock_in(rmii_reference_clock_in),
    .mac_tx_clk(mac_tx_clk), .mac_rx(mac_rx),
    .line_rx_carrier(carrier), .line_rx_sfd(sfd), .line_rx_data(4'hC),
    .line_rx_err(rx_err), .line_energy(energy), .line_tx(line_tx),
    .signal_detect_internal(sdi));

  phy_mac_model mac (.mac_tx_clk(mac_tx_clk),
    .rmii_reference_clock_in(rmii_reference_clock_in), .mode(mode),
    .go(go), .mac_tx(mac_tx));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic check_rng(input string what, input int lo, input int hi,
    input int seen);
    samples_checked++;
    if (seen < lo || seen > hi)
    begin
      n_fail++;
      $display("wrong value %s expected %0d..%0d seen %0d", what, lo, hi,
        seen);
    end
  endtask : check_rng

  task automatic check_bit(input string what, input logic exp,
    input logic seen);
    samples_checked++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("wrong value %s expected %b seen %b", what, exp, seen);
    end
  endtask : check_bit

  // counts settled cycles until a probe bit reaches a level
  task automatic wait_bit(input int b, input logic v, output int n);
    n = 0;
    while (pr[b] !== v && n < 20000)
    begin
      @(negedge sys_clk);
      n++;
    end
    if (pr[b] !== v)
    begin
      n_fail++;
      $display("wrong value probe %0d expected %b seen %b", b, v, pr[b]);
    end
  endtask : wait_bit

  task automatic rise(input int b, output int n);
    int m;
    wait_bit(b, 1'b0, m);
    wait_bit(b, 1'b1, n);
  endtask : rise

  task automatic start(input phy_pkg::phy_mode_t m);
    @(negedge sys_clk);
    mode = m;
    rst = 1'b1;
    repeat (2) @(negedge sys_clk);
    rst = 1'b0;
    repeat (4) @(negedge sys_clk);
  endtask : start

  // toggles enable, finds the sampling edge, times the line marker
  task automatic tx_edge(input logic en, input int sb, input logic sv,
    input int mark, output int n);
    int m;
    go = en;
    wait_bit(EN, en, m);
    wait_bit(sb, ~sv, m);
    wait_bit(sb, sv, m);
    wait_bit(mark, 1'b1, n);
  endtask : tx_edge

  task automatic eop_len(output int n);
    int m;
    wait_bit(EOP, 1'b1, m);
    wait_bit(EOP, 1'b0, n);
  endtask : eop_len

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_tx100();
    int n;
    start(phy_pkg::PHY_M_MII100);
    tx_edge(1'b1, TCK, 1'b1, SS, n);
    check_rng("start lat 100", 7, 10, n);
    check_bit("active 100", 1'b1, line_tx.active);
    repeat (40) @(negedge sys_clk);
    tx_edge(1'b0, TCK, 1'b1, SE, n);
    check_rng("end lat 100", 7, 10, n);
    check_bit("idle 100", 1'b0, line_tx.active);
    $display("test tx100 done");
  endtask : t_tx100

  task automatic t_tx10();
    int n;
    start(phy_pkg::PHY_M_MII10);
    tx_edge(1'b1, TCK, 1'b0, SS, n);
    check_rng("start lat mii10", 42, 47, n);
    repeat (200) @(negedge sys_clk);
    tx_edge(1'b0, TCK, 1'b0, SE, n);
    eop_len(n);
    check_rng("eop high mii10", 32, 40, n);
    $display("test tx10 done");
  endtask : t_tx10

  task automatic t_txser();
    int n;
    start(phy_pkg::PHY_M_SER10);
    rise(TCK, n);
    wait_bit(TCK, 1'b0, n);
    check_rng("ser clk high", 3, 4, n);
    wait_bit(TCK, 1'b1, n);
    check_rng("ser clk low", 8, 10, n);
    tx_edge(1'b1, TCK, 1'b1, SS, n);
    check_rng("start lat ser", 42, 47, n);
    repeat (100) @(negedge sys_clk);
    tx_edge(1'b0, TCK, 1'b1, SE, n);
    eop_len(n);
    check_rng("eop high ser", 32, 40, n);
    $display("test txser done");
  endtask : t_txser

  task automatic t_txrmii();
    int n;
    start(phy_pkg::PHY_M_RMII);
    tx_edge(1'b1, REF, 1'b1, SS, n);
    check_rng("start lat rmii", 21, 28, n);
    repeat (40) @(negedge sys_clk);
    go = 1'b0;
    $display("test txrmii done");
  endtask : t_txrmii

  task automatic t_rx100();
    int a;
    int b;
    start(phy_pkg::PHY_M_MII100);
    rise(RCK, a);
    wait_bit(RCK, 1'b0, a);
    check_rng("rx clk high 100", 2, 3, a);
    @(negedge sys_clk);
    carrier = 1'b1;
    wait_bit(CRS, 1'b1, a);
    check_rng("crs on 100", 25, 30, a);
    wait_bit(DV, 1'b1, b);
    check_rng("dv lat 100", 30, 38, a + b);
    check_bit("rx nibble 100", 1'b1, pr[DC]);
    rx_err = 1'b1;
    wait_bit(RCK, 1'b1, b);
    wait_bit(RCK, 1'b0, b);
    check_bit("rx err 100", 1'b1, mac_rx.er);
    rx_err = 1'b0;
    carrier = 1'b0;
    wait_bit(CRS, 1'b0, a);
    check_rng("crs off 100", 30, 35, a);
    $display("test rx100 done");
  endtask : t_rx100

  task automatic t_rx10();
    int a;
    int b;
    start(phy_pkg::PHY_M_MII10);
    rise(RCK, a);
    wait_bit(RCK, 1'b0, a);
    check_rng("rx clk high 10", 24, 26, a);
    @(negedge sys_clk);
    carrier = 1'b1;
    wait_bit(CRS, 1'b1, a);
    check_rng("crs on 10", 75, 125, a);
    wait_bit(DV, 1'b1, b);
    check_rng("dv lat 10", 125, 180, a + b);
    check_bit("data closed", 1'b0, pr[DC]);
    sfd = 1'b1;
    wait_bit(DC, 1'b1, a);
    check_rng("data after sfd", 100, 155, a);
    carrier = 1'b0;
    sfd = 1'b0;
    $display("test rx10 done");
  endtask : t_rx10

  task automatic t_rxser();
    int n;
    start(phy_pkg::PHY_M_SER10);
    rise(RCK, n);
    wait_bit(RCK, 1'b0, n);
    check_rng("ser rx clk high", 6, 7, n);
    $display("test rxser done");
  endtask : t_rxser

  task automatic t_links();
    int a;
    int b;
    int cnt;
    logic prev;
    autoneg_en = 1'b0;
    start(phy_pkg::PHY_M_MII10);
    rise(LPB, a);
    wait_bit(LPB, 1'b0, a);
    check_rng("nlp width", 13, 13, a);
    wait_bit(LPB, 1'b1, b);
    check_rng("nlp period", LP - 1, LP + 1, a + b);
    autoneg_en = 1'b1;
    start(phy_pkg::PHY_M_MII100);
    rise(LPB, a);
    wait_bit(LPB, 1'b0, a);
    wait_bit(LPB, 1'b1, b);
    check_rng("flp data gap", DATA - 1, DATA + 1, a + b);
    // slot 0 clock, slot 0 data and slot 1 clock are already past
    cnt = 3;
    prev = 1'b1;
    repeat (16 * SLOT - DATA)
    begin
      @(negedge sys_clk);
      cnt += (pr[LPB] && !prev) ? 1 : 0;
      prev = pr[LPB];
    end
    check_rng("flp pulses", 24, 24, cnt);
    autoneg_en = 1'b0;
    $display("test links done");
  endtask : t_links

  task automatic t_det();
    int n;
    start(phy_pkg::PHY_M_MII100);
    energy = 1'b1;
    wait_bit(DET, 1'b1, n);
    check_rng("detect on", DET_ON, DET_ON + 4, n);
    energy = 1'b0;
    wait_bit(DET, 1'b0, n);
    check_rng("detect off", DET_OFF, DET_OFF + 4, n);
    $display("test detect done");
  endtask : t_det

  // ----------------------------------------------------------------
  // run control
  // ----------------------------------------------------------------
  task automatic finish_test();
    $display("checks %0d failures %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : finish_test

  initial
  begin
    #800000;
    n_fail++;
    finish_test();
  end

  initial
  begin
    repeat (20) @(negedge sys_clk);
    rst = 1'b0;
    t_tx100();
    t_tx10();
    t_txser();
    t_txrmii();
    t_rx100();
    t_rx10();
    t_rxser();
    t_links();
    t_det();
    finish_test();
  end
endmodule : phy_datapath_bench
